// [sas_pkg.sv]
/*
 * Shared constants for the successive-approximation converter sequencer:
 * register offsets, field positions, reset values, modes and phase lengths.
 * Assumes a 16-bit register port with a 4-bit word address.
 */
package sas_pkg;

   // Register port geometry.
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;

   // Register offsets (word addresses).
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_RANGE = 4'h1;
   localparam logic [3:0] OFS_CMD = 4'h2;
   localparam logic [3:0] OFS_STATUS = 4'h3;
   localparam logic [3:0] OFS_INT_STAT = 4'h4;
   localparam logic [3:0] OFS_INT_MASK = 4'h5;
   localparam logic [3:0] OFS_RESULT = 4'h6;

   // Control register fields.
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_TRIG_LSB = 2;
   localparam int unsigned CTRL_RES10 = 4;
   localparam int unsigned CTRL_SMP_LSB = 5;
   localparam int unsigned CTRL_CMP_LSB = 7;
   localparam int unsigned CTRL_SVC = 9;
   localparam int unsigned CTRL_USED_W = 10;

   // Range, command, status, interrupt and result fields.
   localparam int unsigned RANGE_START_LSB = 0;
   localparam int unsigned RANGE_END_LSB = 4;
   localparam int unsigned CMD_START = 0;
   localparam int unsigned CMD_STOP = 1;
   localparam int unsigned STATUS_BUSY = 0;
   localparam int unsigned STATUS_SAMPLING = 1;
   localparam int unsigned STATUS_CHAN_LSB = 4;
   localparam int unsigned STATUS_AUTO_PEND = 8;
   localparam int unsigned INT_DONE = 0;
   localparam int unsigned INT_SEQ_END = 1;
   localparam int unsigned INT_W = 2;
   localparam int unsigned RESULT_CHAN_LSB = 12;

   // Reset values.
   localparam logic [CTRL_USED_W-1:0] CTRL_RST = 10'h000;
   localparam logic [2:0] RANGE_START_RST = 3'h0;
   localparam logic [2:0] RANGE_END_RST = 3'h7;
   localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;

   // Channel and result geometry.
   localparam int unsigned CHAN_W = 3;
   localparam int unsigned RES_W = 10;
   localparam int unsigned CNT_W = 12;
   localparam logic [RES_W-1:0] SAR_MSB = 10'h200;
   localparam logic [RES_W-1:0] SAR_LSB10 = 10'h001;
   localparam logic [RES_W-1:0] SAR_LSB8 = 10'h004;
   localparam int unsigned STEPS_8 = 8;
   localparam int unsigned STEPS_10 = 10;

   // Sampling and compare phase lengths in machine cycles.
   localparam int unsigned SMP_CYC_0 = 64;
   localparam int unsigned SMP_CYC_1 = 128;
   localparam int unsigned SMP_CYC_2 = 4096;
   localparam int unsigned CMP_CYC_0 = 44;
   localparam int unsigned CMP_CYC_1 = 99;
   localparam int unsigned CMP_CYC_2 = 176;

   // Length of one approximation step, compare phase shared evenly by the steps.
   localparam int unsigned STEP_CYC_0_8 = CMP_CYC_0 / STEPS_8;
   localparam int unsigned STEP_CYC_0_10 = CMP_CYC_0 / STEPS_10;
   localparam int unsigned STEP_CYC_1_8 = CMP_CYC_1 / STEPS_8;
   localparam int unsigned STEP_CYC_1_10 = CMP_CYC_1 / STEPS_10;
   localparam int unsigned STEP_CYC_2_8 = CMP_CYC_2 / STEPS_8;
   localparam int unsigned STEP_CYC_2_10 = CMP_CYC_2 / STEPS_10;

   // Conversion modes; code 3 is illegal and behaves as single-shot.
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_CONT = 2'h1,
      MODE_INCR = 2'h2
   } sas_mode_t;

   // Trigger sources; code 3 never starts a conversion.
   localparam logic [1:0] TRIG_SW = 2'h0;
   localparam logic [1:0] TRIG_TIMER = 2'h1;
   localparam logic [1:0] TRIG_EXT = 2'h2;

   // Sequencer states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SAMPLE = 3'h2,
      ST_COMPARE = 3'h4
   } sas_state_t;

endpackage : sas_pkg

// [sas_sync3.sv]
/*
 * Three-stage synchroniser with agreement filter for pin inputs.
 * Assumes inputs are asynchronous to clk_sys; the output changes only
 * when the second and third stages agree.
 */
`timescale 1ns/10ps
module sas_sync3 #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Raw pins and filtered levels.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out
);

   logic [W-1:0] s1_reg;   // First stage, read only by the second stage.
   logic [W-1:0] s2_reg;   // Second stage.
   logic [W-1:0] s3_reg;   // Third stage.
   logic [W-1:0] hold_reg; // Last agreed level.
   logic [W-1:0] hold_next;

   // An agreed level passes straight through, so the filter adds no extra cycle.
   always_comb begin
      hold_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (hold_reg & (s2_reg ^ s3_reg));
   end

   assign level_out = hold_next;

   // All stages reset to the idle level so no false edge follows reset.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         hold_reg <= RST_VAL;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         hold_reg <= hold_next;
      end
   end

endmodule : sas_sync3

// [sas_sar_adc_sequencer.sv]
/*
 * Sequencer and successive-approximation control for an eight-input converter.
 * Assumes an external sample-and-hold, a trial-code array and a comparator whose
 * output is high while the held input is at or above the trial code.
 */
`timescale 1ns/10ps

// Behaviour
// - Sampling lasts 64, 128 or 4096 cycles
// - Compare lasts 44, 99 or 176 cycles
// - Compare starts only after sampling ends
// - One result bit decided per comparator step
// - Resolution selects 8 or 10 steps
// - Exactly one of eight channels connected while converting
// - Enabled interrupt on each completion
// - Completion may request automatic transfer service instead
// - Start by software, timer or falling pin
// - Single-shot converts start to end, stops
// - Continuous wraps to start without trigger
// - Incremental converts one channel per trigger
// - Incremental wraps from end to start
module sas_sar_adc_sequencer
   import sas_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register port.
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Conversion triggers.
   input wire logic timer_trig,
   input wire logic ext_trig_pin,
   // Analog front end.
   output logic [CHAN_W-1:0] ana_chan_sel,
   output logic ana_chan_connect,
   output logic ana_sample,
   output logic [RES_W-1:0] ana_trial_code,
   input wire logic ana_cmp_pin,
   // Completion requests.
   output logic irq,
   output logic auto_transfer_service_req,
   input wire logic auto_transfer_service_ack
);

   // Sequencer state.
   sas_state_t state_reg, state_next;
   logic [CNT_W-1:0] phase_cnt_reg, phase_cnt_next;   // Cycles left in the phase.
   logic [CNT_W-1:0] step_cnt_reg, step_cnt_next;     // Cycles left in the step.
   logic [RES_W-1:0] bit_mask_reg, bit_mask_next;     // Bit under test, one-hot.
   logic [RES_W-1:0] trial_reg, trial_next;           // Trial code to the array.
   logic [CHAN_W-1:0] chan_reg, chan_next;            // Current or next channel.
   logic [RES_W-1:0] result_reg, result_next;         // Last finished result.
   logic [CHAN_W-1:0] res_chan_reg, res_chan_next;    // Channel of that result.
   logic ext_lvl_reg;                                 // Previous filtered pin level.

   // Register state.
   logic [CTRL_USED_W-1:0] ctrl_reg, ctrl_next;
   logic [CHAN_W-1:0] start_reg, start_next;
   logic [CHAN_W-1:0] end_reg, end_next;
   logic [INT_W-1:0] int_stat_reg, int_stat_next;
   logic [INT_W-1:0] int_mask_reg, int_mask_next;
   logic auto_pend_reg, auto_pend_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   // Decoded control fields and events.
   sas_mode_t mode;
   logic [1:0] trig_src;
   logic res10;
   logic svc_sel;
   logic [CNT_W-1:0] smp_last;
   logic [CNT_W-1:0] cmp_last;
   logic [CNT_W-1:0] step_last;
   logic [RES_W-1:0] lsb_mask;
   logic cmd_start;
   logic cmd_stop;
   logic trig_fire;
   logic ext_fall;
   logic done_pulse;
   logic seq_end_pulse;
   logic [1:0] sync_lvl;
   logic ext_lvl;
   logic cmp_lvl;

   // Both pins come from outside the clock domain; trigger idles high.
   sas_sync3 #(
      .W(2),
      .RST_VAL(2'h1)
   ) u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_in({ana_cmp_pin, ext_trig_pin}),
      .level_out(sync_lvl)
   );

   assign ext_lvl = sync_lvl[0];
   assign cmp_lvl = sync_lvl[1];

   // Field decode and phase length lookup.
   always_comb begin
      mode = sas_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
      trig_src = ctrl_reg[CTRL_TRIG_LSB +: 2];
      res10 = ctrl_reg[CTRL_RES10];
      svc_sel = ctrl_reg[CTRL_SVC];
      lsb_mask = res10 ? SAR_LSB10 : SAR_LSB8;
      // Sampling length, code 3 falls back to the longest setting.
      unique case (ctrl_reg[CTRL_SMP_LSB +: 2])
         2'h0: smp_last = CNT_W'(SMP_CYC_0 - 1);
         2'h1: smp_last = CNT_W'(SMP_CYC_1 - 1);
         default: smp_last = CNT_W'(SMP_CYC_2 - 1);
      endcase
      // Compare length and the matching step length for the resolution.
      unique case (ctrl_reg[CTRL_CMP_LSB +: 2])
         2'h0: begin
            cmp_last = CNT_W'(CMP_CYC_0 - 1);
            step_last = res10 ? CNT_W'(STEP_CYC_0_10 - 1) : CNT_W'(STEP_CYC_0_8 - 1);
         end
         2'h1: begin
            cmp_last = CNT_W'(CMP_CYC_1 - 1);
            step_last = res10 ? CNT_W'(STEP_CYC_1_10 - 1) : CNT_W'(STEP_CYC_1_8 - 1);
         end
         default: begin
            cmp_last = CNT_W'(CMP_CYC_2 - 1);
            step_last = res10 ? CNT_W'(STEP_CYC_2_10 - 1) : CNT_W'(STEP_CYC_2_8 - 1);
         end
      endcase
   end

   // Command strobes and the trigger selected by software.
   always_comb begin
      cmd_start = reg_wr && (reg_addr == OFS_CMD) && reg_wdata[CMD_START];
      cmd_stop = reg_wr && (reg_addr == OFS_CMD) && reg_wdata[CMD_STOP];
      ext_fall = ext_lvl_reg && !ext_lvl;
      unique case (trig_src)
         TRIG_SW: trig_fire = cmd_start;
         TRIG_TIMER: trig_fire = timer_trig;
         TRIG_EXT: trig_fire = ext_fall;
         default: trig_fire = 1'b0;
      endcase
   end

   // Sequencer next state. Triggers arriving while busy are ignored, since the
   // front end has a single sampler and a second conversion cannot overlap.
   always_comb begin
      state_next = state_reg;
      phase_cnt_next = phase_cnt_reg;
      step_cnt_next = step_cnt_reg;
      bit_mask_next = bit_mask_reg;
      trial_next = trial_reg;
      chan_next = chan_reg;
      result_next = result_reg;
      res_chan_next = res_chan_reg;
      done_pulse = 1'b0;
      seq_end_pulse = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            // A new range while idle repositions the channel pointer.
            if (reg_wr && (reg_addr == OFS_RANGE)) begin
               chan_next = reg_wdata[RANGE_START_LSB +: CHAN_W];
            end
            if (trig_fire && !cmd_stop) begin
               // Incremental mode keeps its pointer; other modes restart the range.
               if (mode != MODE_INCR) begin
                  chan_next = start_reg;
               end
               state_next = ST_SAMPLE;
               phase_cnt_next = smp_last;
            end
         end
         ST_SAMPLE: begin
            if (phase_cnt_reg == '0) begin
               // Compare begins on the cycle after the last sampling cycle.
               state_next = ST_COMPARE;
               phase_cnt_next = cmp_last;
               step_cnt_next = step_last;
               bit_mask_next = SAR_MSB;
               trial_next = SAR_MSB;
            end else begin
               phase_cnt_next = phase_cnt_reg - CNT_W'(1);
            end
         end
         ST_COMPARE: begin
            phase_cnt_next = phase_cnt_reg - CNT_W'(1);
            if (bit_mask_reg != '0) begin
               if (step_cnt_reg == '0) begin
                  // Keep the bit when the input is at or above the trial code.
                  trial_next = cmp_lvl ? trial_reg : (trial_reg & ~bit_mask_reg);
                  bit_mask_next = (bit_mask_reg == lsb_mask) ? '0 : (bit_mask_reg >> 1);
                  trial_next = trial_next | bit_mask_next;
                  step_cnt_next = step_last;
               end else begin
                  step_cnt_next = step_cnt_reg - CNT_W'(1);
               end
            end
            if (phase_cnt_reg == '0) begin
               // The final step may end on this very cycle, so use trial_next.
               result_next = res10 ? trial_next : {2'h0, trial_next[RES_W-1:2]};
               res_chan_next = chan_reg;
               done_pulse = 1'b1;
               chan_next = (chan_reg == end_reg) ? start_reg : (chan_reg + CHAN_W'(1));
               unique case (mode)
                  MODE_CONT: begin
                     state_next = ST_SAMPLE;
                     phase_cnt_next = smp_last;
                     seq_end_pulse = (chan_reg == end_reg);
                  end
                  MODE_INCR: begin
                     state_next = ST_IDLE;
                     seq_end_pulse = (chan_reg == end_reg);
                  end
                  default: begin
                     seq_end_pulse = (chan_reg == end_reg);
                     if (chan_reg == end_reg) begin
                        state_next = ST_IDLE;
                        chan_next = start_reg;
                     end else begin
                        state_next = ST_SAMPLE;
                        phase_cnt_next = smp_last;
                     end
                  end
               endcase
            end
         end
      endcase
      // Stop wins over everything, including a completion in the same cycle.
      if (cmd_stop) begin
         state_next = ST_IDLE;
         done_pulse = 1'b0;
         seq_end_pulse = 1'b0;
         result_next = result_reg;
         res_chan_next = res_chan_reg;
         bit_mask_next = '0;
         if (state_reg != ST_IDLE) begin
            chan_next = chan_reg;
         end
      end
   end

   // Register file next values. Hardware sets win over software clears.
   always_comb begin
      ctrl_next = ctrl_reg;
      start_next = start_reg;
      end_next = end_reg;
      int_mask_next = int_mask_reg;
      int_stat_next = int_stat_reg;
      rdata_next = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_CTRL: ctrl_next = reg_wdata[CTRL_USED_W-1:0];
            OFS_RANGE: begin
               start_next = reg_wdata[RANGE_START_LSB +: CHAN_W];
               end_next = reg_wdata[RANGE_END_LSB +: CHAN_W];
            end
            OFS_INT_STAT: int_stat_next = int_stat_reg & ~reg_wdata[INT_W-1:0];
            OFS_INT_MASK: int_mask_next = reg_wdata[INT_W-1:0];
            default: ;
         endcase
      end
      // Completion goes to the interrupt path or to the transfer service.
      int_stat_next[INT_DONE] = int_stat_next[INT_DONE] | (done_pulse && !svc_sel);
      int_stat_next[INT_SEQ_END] = int_stat_next[INT_SEQ_END] | seq_end_pulse;
      auto_pend_next = (auto_pend_reg && !auto_transfer_service_ack)
                       || (done_pulse && svc_sel);
      // Read data appear one cycle after the strobe; unmapped reads return zero.
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CTRL: rdata_next[CTRL_USED_W-1:0] = ctrl_reg;
            OFS_RANGE: begin
               rdata_next[RANGE_START_LSB +: CHAN_W] = start_reg;
               rdata_next[RANGE_END_LSB +: CHAN_W] = end_reg;
            end
            OFS_STATUS: begin
               rdata_next[STATUS_BUSY] = (state_reg != ST_IDLE);
               rdata_next[STATUS_SAMPLING] = (state_reg == ST_SAMPLE);
               rdata_next[STATUS_CHAN_LSB +: CHAN_W] = chan_reg;
               rdata_next[STATUS_AUTO_PEND] = auto_pend_reg;
            end
            OFS_INT_STAT: rdata_next[INT_W-1:0] = int_stat_reg;
            OFS_INT_MASK: rdata_next[INT_W-1:0] = int_mask_reg;
            OFS_RESULT: begin
               rdata_next[RES_W-1:0] = result_reg;
               rdata_next[RESULT_CHAN_LSB +: CHAN_W] = res_chan_reg;
            end
            default: ;
         endcase
      end
   end

   // State registers.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         phase_cnt_reg <= '0;
         step_cnt_reg <= '0;
         bit_mask_reg <= '0;
         trial_reg <= '0;
         chan_reg <= RANGE_START_RST;
         result_reg <= '0;
         res_chan_reg <= '0;
         ext_lvl_reg <= 1'b1;
         ctrl_reg <= CTRL_RST;
         start_reg <= RANGE_START_RST;
         end_reg <= RANGE_END_RST;
         int_stat_reg <= '0;
         int_mask_reg <= INT_MASK_RST;
         auto_pend_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         state_reg <= state_next;
         phase_cnt_reg <= phase_cnt_next;
         step_cnt_reg <= step_cnt_next;
         bit_mask_reg <= bit_mask_next;
         trial_reg <= trial_next;
         chan_reg <= chan_next;
         result_reg <= result_next;
         res_chan_reg <= res_chan_next;
         ext_lvl_reg <= ext_lvl;
         ctrl_reg <= ctrl_next;
         start_reg <= start_next;
         end_reg <= end_next;
         int_stat_reg <= int_stat_next;
         int_mask_reg <= int_mask_next;
         auto_pend_reg <= auto_pend_next;
         rdata_reg <= rdata_next;
      end
   end

   // Only one channel is ever routed, and only while a conversion runs.
   assign ana_chan_sel = chan_reg;
   assign ana_chan_connect = (state_reg != ST_IDLE);
   assign ana_sample = (state_reg == ST_SAMPLE);
   assign ana_trial_code = trial_reg;
   assign reg_rdata = rdata_reg;
   assign irq = |(int_stat_reg & int_mask_reg);
   assign auto_transfer_service_req = auto_pend_reg;

endmodule : sas_sar_adc_sequencer

// [sas_seq_checker.sv]
/* Port checker for the converter sequencer.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module sas_seq_checker
   import sas_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register port.
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Analog side and requests.
   input wire logic [CHAN_W-1:0] ana_chan_sel,
   input wire logic ana_chan_connect,
   input wire logic ana_sample,
   input wire logic [RES_W-1:0] ana_trial_code,
   input wire logic irq,
   input wire logic auto_transfer_service_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [12:0] smp_cnt_reg; // Sampling cycles seen so far.
   logic [CTRL_USED_W-1:0] ctrl_reg; // Shadow of the control register.
   logic cmd_wr;
   logic stop_wr;
   assign cmd_wr = reg_wr && reg_addr == OFS_CMD;
   assign stop_wr = cmd_wr && reg_wdata[CMD_STOP];
   // The counter restarts whenever sampling is off, so it holds one phase length.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         smp_cnt_reg <= '0;
         ctrl_reg <= CTRL_RST;
      end else begin
         smp_cnt_reg <= ana_sample ? smp_cnt_reg + 13'h0001 : 13'h0000;
         if (reg_wr && reg_addr == OFS_CTRL) begin
            ctrl_reg <= reg_wdata[CTRL_USED_W-1:0];
         end
      end
   end
   AST_SMP_LEN: assert property ($fell(ana_sample) && !$past(stop_wr) |->
      smp_cnt_reg inside {13'h0040, 13'h0080, 13'h1000}) else $error("sampling length wrong");
   AST_SMP_CONN: assert property (ana_sample |-> ana_chan_connect)
      else $error("sampling without connection");
   AST_MSB_FIRST: assert property ($fell(ana_sample) && !$past(stop_wr) |->
      ana_chan_connect && ana_trial_code == SAR_MSB) else $error("compare not from msb");
   AST_STEP8: assert property (ana_chan_connect && !ana_sample && !ctrl_reg[CTRL_RES10] |->
      ana_trial_code[1:0] == 2'h0) else $error("8-bit trial has low bits");
   AST_CHAN_HOLD: assert property (ana_chan_connect && !$rose(ana_sample) |->
      $stable(ana_chan_sel)) else $error("channel changed mid conversion");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside read slot");
   AST_CMD_RD: assert property ($past(reg_rd) && $past(reg_addr) == OFS_CMD |-> reg_rdata == '0)
      else $error("command register read nonzero");
   AST_START: assert property (cmd_wr && reg_wdata[CMD_START] && !reg_wdata[CMD_STOP] &&
      ctrl_reg[CTRL_TRIG_LSB+:2] == TRIG_SW && !ana_chan_connect |=>
      ana_sample && ana_chan_connect) else $error("software start ignored");
   AST_STOP: assert property (stop_wr |=> !ana_chan_connect && !$rose(irq) &&
      !$rose(auto_transfer_service_req)) else $error("stop did not abort silently");
   AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(ana_chan_connect) || $past(reg_wr))
      else $error("interrupt without cause");
   AST_ATS_CAUSE: assert property ($rose(auto_transfer_service_req) |->
      $past(ana_chan_connect) && ctrl_reg[CTRL_SVC]) else $error("transfer request without cause");
   COV_SAMPLE: cover property ($fell(ana_sample));
   COV_IRQ: cover property ($rose(irq));
   COV_ATS: cover property ($rose(auto_transfer_service_req));
endmodule : sas_seq_checker

bind sas_sar_adc_sequencer sas_seq_checker chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ana_chan_sel(ana_chan_sel), .ana_chan_connect(ana_chan_connect),
   .ana_sample(ana_sample), .ana_trial_code(ana_trial_code), .irq(irq),
   .auto_transfer_service_req(auto_transfer_service_req));

// [sas_analog_model.sv]
/* Behavioural sample-and-hold, trial array and comparator.
   Assumes the sequencer drives channel, connect, sample and trial code. */
`timescale 1ns/10ps
module sas_analog_model
   import sas_pkg::*;
#(
   parameter logic [RES_W-1:0] LVL_BASE = 10'h05A,
   parameter logic [RES_W-1:0] LVL_STEP = 10'h07B
) (
   // Clock.
   input wire logic clk_sys,
   // Sequencer side.
   input wire logic [CHAN_W-1:0] ana_chan_sel,
   input wire logic ana_chan_connect,
   input wire logic ana_sample,
   input wire logic [RES_W-1:0] ana_trial_code,
   output logic ana_cmp_pin
);
   logic [RES_W-1:0] held_reg; // Charge on the hold capacitor, as a code.
   logic flip_reg = 1'b0; // Meaningless level shown when nothing is compared.
   // Each channel carries a distinct level so a wrong channel shows in the result.
   always_ff @(posedge clk_sys) begin
      flip_reg <= !flip_reg;
      if (ana_sample && ana_chan_connect) begin
         held_reg <= LVL_BASE + RES_W'(ana_chan_sel) * LVL_STEP;
      end
   end
   // Settles at once, so short phases need no real-time minimum here.
   // Outside compare the pin toggles so stale use is caught.
   assign ana_cmp_pin = (ana_chan_connect && !ana_sample) ?
      (held_reg >= ana_trial_code) : flip_reg;
endmodule : sas_analog_model

// [tb_sas_sar_adc_sequencer.sv]
/* Self-checking bench for the converter sequencer.
   Assumes the analog model answers promptly on the comparator pin. */
`timescale 1ns/10ps
module tb_sas_sar_adc_sequencer
   import sas_pkg::*;
;
   logic clk_sys, sys_rst, reg_wr, reg_rd, timer_trig, ext_trig_pin, ana_cmp_pin, irq;
   logic ana_chan_connect, ana_sample, auto_transfer_service_req, auto_transfer_service_ack;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [CHAN_W-1:0] ana_chan_sel;
   logic [RES_W-1:0] ana_trial_code;
   logic [15:0] cyc [3] = '{16'h006C, 16'h00E3, 16'h10B0}; // Sampling plus compare.
   int n_errors = 0;
   int total_checks = 0;
   int n;
   // Every port meets the bench signal of the same name.
   sas_sar_adc_sequencer dut_u (.*);
   sas_analog_model ana_u (.*);
   // Free-running 200 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic give_verdict;
      if (n_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Bus tasks start and end just after a rising edge.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      // One idle edge, so a following write never drives the strobe twice at once.
      @(posedge clk_sys);
   endtask : wr
   task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      check(what, reg_rdata, exp);
      @(posedge clk_sys);
   endtask : rdc
   // Looks at the level output mid-cycle, where it has settled.
   task automatic chk_irq(input logic exp);
      @(negedge clk_sys);
      check("irq", irq, exp);
      @(posedge clk_sys);
   endtask : chk_irq
   // Waits for completion, checks the result, then retires the request.
   task automatic conv(input logic [2:0] ch, input logic r10, input logic ats);
      logic [RES_W-1:0] v;
      v = 10'h05A + RES_W'(ch) * 10'h07B;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while ((ats ? auto_transfer_service_req : irq) !== 1'b1 && n < 6000);
      if (n == 6000) n_errors++;
      @(posedge clk_sys);
      rdc("result", OFS_RESULT, {1'b0, ch, 2'h0, r10 ? v : v >> 2});
      if (ats) begin
         auto_transfer_service_ack <= 1'b1;
         @(posedge clk_sys);
         auto_transfer_service_ack <= 1'b0;
         @(negedge clk_sys);
         check("transfer request", auto_transfer_service_req, 1'b0);
         @(posedge clk_sys);
      end else begin
         wr(OFS_INT_STAT, 16'h0003);
         chk_irq(1'b0);
      end
   endtask : conv
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_errors++;
      give_verdict();
   end
   initial begin
      {sys_rst, ext_trig_pin} = 2'h3;
      {reg_wr, reg_rd, timer_trig, auto_transfer_service_ack} = 4'h0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rdc("ctrl", OFS_CTRL, 16'h0000);
      rdc("range", OFS_RANGE, 16'h0070);
      rdc("mask", OFS_INT_MASK, 16'h0000);
      rdc("cmd", OFS_CMD, 16'h0000);
      rdc("unmapped", 4'hF, 16'h0000);
      wr(OFS_INT_MASK, 16'h0001);
      // Every phase setting once, alternating resolution, one channel each.
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CTRL, 16'((i << CTRL_SMP_LSB) | (i << CTRL_CMP_LSB) | ((i % 2) << CTRL_RES10)));
         wr(OFS_RANGE, 16'(((i + 1) << RANGE_END_LSB) | (i + 1)));
         wr(OFS_CMD, 16'h0001);
         conv(3'(i + 1), 1'(i % 2), 1'b0);
         check("cycles", 16'(n), cyc[i]);
      end
      // Single-shot over two channels must then stay idle.
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_RANGE, 16'h0065);
      wr(OFS_CMD, 16'h0001);
      conv(3'h5, 1'b0, 1'b0);
      conv(3'h6, 1'b0, 1'b0);
      repeat (300) @(posedge clk_sys);
      rdc("status", OFS_STATUS, 16'h0050);
      // Continuous from the timer wraps, then a stop mid-sampling is silent.
      wr(OFS_CTRL, {12'h000, TRIG_TIMER, MODE_CONT});
      wr(OFS_RANGE, 16'h0076);
      timer_trig <= 1'b1;
      @(posedge clk_sys);
      timer_trig <= 1'b0;
      for (int i = 0; i < 3; i++) conv(3'(6 + i % 2), 1'b0, 1'b0);
      repeat (30) @(posedge clk_sys);
      wr(OFS_CMD, 16'h0002);
      repeat (300) @(posedge clk_sys);
      chk_irq(1'b0);
      rdc("status", OFS_STATUS, 16'h0070);
      // Incremental from falling pin edges, routed to transfer service.
      wr(OFS_CTRL, 16'((1 << CTRL_SVC) | (TRIG_EXT << CTRL_TRIG_LSB) | MODE_INCR));
      wr(OFS_RANGE, 16'h0043);
      for (int k = 0; k < 3; k++) begin
         ext_trig_pin <= 1'b0;
         repeat (8) @(posedge clk_sys);
         ext_trig_pin <= 1'b1;
         conv(3'(3 + k % 2), 1'b0, 1'b1);
         repeat (300) @(posedge clk_sys);
         rdc("status", OFS_STATUS, 16'((4 - k % 2) << STATUS_CHAN_LSB));
      end
      rdc("int stat", OFS_INT_STAT, 16'h0002);
      chk_irq(1'b0);
      wr(OFS_INT_MASK, 16'h0002);
      chk_irq(1'b1);
      wr(OFS_INT_STAT, 16'h0002);
      chk_irq(1'b0);
      give_verdict();
   end
endmodule : tb_sas_sar_adc_sequencer
